// ===== dus_buf2.sv
// two-entry valid/ready buffer between the latch and the converter
`default_nettype none
module dus_buf2 #(
  parameter int unsigned W = dus_pkg::CODE_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  logic [W-1:0] tail;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic push;
  logic pop;

  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // occupancy follows pushes and pops
  always_comb begin
    next_cnt = cnt;
    if (push && !pop) begin
      next_cnt = cnt + 2'd1;
    end else if (pop && !push) begin
      next_cnt = cnt - 2'd1;
    end
  end

  // head feeds the converter directly, tail only holds a word during a stall
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_data_o <= {W{1'b0}};
      tail <= {W{1'b0}};
    end else begin
      if (cnt == 2'd0 && push) begin
        out_data_o <= in_data_i;
      end else if (cnt == 2'd1) begin
        if (push && pop) begin
          out_data_o <= in_data_i;
        end else if (push) begin
          tail <= in_data_i;
        end
      end else if (cnt == 2'd2 && pop) begin
        out_data_o <= tail;
      end
    end
  end

  // flags registered from the next occupancy so they stay honest
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 2'd0;
      out_valid_o <= 1'b0;
      in_ready_o <= 1'b1;
    end else begin
      cnt <= next_cnt;
      out_valid_o <= (next_cnt != 2'd0);
      in_ready_o <= (next_cnt != 2'(dus_pkg::BUF_DEPTH));
    end
  end
endmodule // dus_buf2
`default_nettype wire

// ===== dus_pkg.sv
// shared constants, types and helpers of the converter update scheduler
`default_nettype none
package dus_pkg;
  // structure
  localparam int unsigned NUM_CH = 2;
  localparam int unsigned CODE_W = 12;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned BUS_W = 32;
  localparam int unsigned BUF_DEPTH = 2;

  // byte addresses on the register bus
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] OFS_LOW = 8'h00;
  localparam logic [7:0] OFS_HIGH = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_LATCH = 8'h0c;
  localparam logic [7:0] OFS_BIAS = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;

  // control register layout
  localparam int unsigned CTRL_EN_BIT = 7;
  localparam int unsigned CTRL_MD_HI = 4;
  localparam int unsigned CTRL_MD_LO = 3;
  localparam int unsigned CTRL_DF_HI = 2;
  localparam int unsigned CTRL_DF_LO = 0;
  localparam logic [7:0] CTRL_WMASK = 8'h9f;

  // status register layout: pending bits then buffer-full bits
  localparam int unsigned STAT_PEND_LO = 0;
  localparam int unsigned STAT_FULL_LO = 4;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic BIAS_RST = 1'b0;
  localparam logic [11:0] CODE_RST = 12'h000;

  // update-mode codes
  typedef enum logic [1:0] {
    MD_DEMAND = 2'b00,
    MD_TMR3 = 2'b01,
    MD_TMR4 = 2'b10,
    MD_TMR2 = 2'b11
  } dus_mode_e;

  // bus handshake states, gray along idle -> ack
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } dus_bus_e;

  // join the two data bytes into one code according to the format field
  function automatic logic [11:0] dus_format(input logic [7:0] hi, input logic [7:0] lo,
                                             input logic [2:0] df);
    logic [11:0] w;
    w = {hi[3:0], lo};
    unique casez (df)
      3'b000: w = {hi[3:0], lo};
      3'b001: w = {hi[4:0], lo[7:1]};
      3'b010: w = {hi[5:0], lo[7:2]};
      3'b011: w = {hi[6:0], lo[7:3]};
      3'b1??: w = {hi, lo[7:4]};
    endcase
    return w;
  endfunction
endpackage
`default_nettype wire

// ===== dus_sink.sv
// converter-side receiver model with an optional stall
`default_nettype none
module dus_sink (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  output logic ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  // slow takes one cycle in sixteen: slower than a put every six cycles,
  // so the two-entry buffer really fills and on-demand high writes stall
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 4'h0;
      ready_o <= 1'b0;
    end else begin
      cnt <= cnt + 4'h1;
      ready_o <= !slow_i || cnt == 4'hf;
    end
  end
endmodule // dus_sink
`default_nettype wire

// ===== dus_top.sv
// update scheduler for two 12-bit converters with an avalon-mm register slave
`default_nettype none
module dus_top (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic TMR2_OVF_I,
  input wire logic TMR3_OVF_I,
  input wire logic TMR4_OVF_I,
  output logic [1:0][11:0] DAC_CODE_O,
  output logic [1:0] DAC_VALID_O,
  input wire logic [1:0] DAC_READY_I,
  output logic [1:0] DAC_OE_O
);
  // address match for a register of one channel
  function automatic logic ch_hit(input logic [7:0] addr, input int unsigned ch,
                                  input logic [7:0] ofs);
    logic [7:0] base;
    base = 8'(ch) * dus_pkg::CH_STRIDE;
    return addr == (base + ofs);
  endfunction

  dus_pkg::dus_bus_e bus_state;
  logic [7:0] dac_low_byte [2];
  logic [7:0] dac_high_byte [2];
  logic [7:0] dac_control_reg [2];
  logic [11:0] latch_code [2];
  logic reference_bias_on;
  logic [1:0] pend;
  logic [1:0] buf_ready;
  logic [1:0] buf_valid;
  logic [1:0] tmr_load;
  logic [1:0] dem_load;
  logic [1:0] load;
  logic [1:0] demand_stall;
  logic [11:0] load_word [2];
  logic [31:0] next_rdata;
  logic wr_fire;
  logic lane0;
  logic stall;

  // a write takes effect at the edge where the master sees waitrequest low
  assign wr_fire = (bus_state == dus_pkg::BUS_ACK) && AVS_WRITE_I;
  assign lane0 = AVS_BYTEENABLE_I[0];
  assign stall = |demand_stall;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      logic [1:0] mode;
      logic [2:0] fmt;
      logic high_wr;

      assign mode = dac_control_reg[g][dus_pkg::CTRL_MD_HI:dus_pkg::CTRL_MD_LO];
      assign fmt = dac_control_reg[g][dus_pkg::CTRL_DF_HI:dus_pkg::CTRL_DF_LO];
      assign high_wr = AVS_WRITE_I && lane0 && ch_hit(AVS_ADDRESS_I, g, dus_pkg::OFS_HIGH);

      // an on-demand high write waits while the buffer is full or a timer load is owed
      assign demand_stall[g] = (bus_state == dus_pkg::BUS_IDLE) && high_wr &&
                               (mode == dus_pkg::MD_DEMAND) && (!buf_ready[g] || pend[g]);

      // immediate load on a high write in mode zero, using the new high byte
      assign dem_load[g] = wr_fire && high_wr && (mode == dus_pkg::MD_DEMAND);

      // a timer load waits for buffer space instead of dropping the event
      assign tmr_load[g] = pend[g] && buf_ready[g] && !dem_load[g];
      assign load[g] = dem_load[g] | tmr_load[g];

      // stored low byte with the written or the stored high byte, through the chosen alignment
      always_comb begin
        if (dem_load[g]) begin
          load_word[g] = dus_pkg::dus_format(AVS_WRITEDATA_I[7:0], dac_low_byte[g], fmt);
        end else begin
          load_word[g] = dus_pkg::dus_format(dac_high_byte[g], dac_low_byte[g], fmt);
        end
      end

      // selected overflow leaves a pending load until it is carried out
      dus_trig u_trig (
        .clk_i(SYS_CLK_I),
        .rst_i(SYS_RST_I),
        .mode_i(mode),
        .tmr2_ovf_i(TMR2_OVF_I),
        .tmr3_ovf_i(TMR3_OVF_I),
        .tmr4_ovf_i(TMR4_OVF_I),
        .load_done_i(tmr_load[g]),
        .pend_o(pend[g])
      );

      // the receiver may stall; two entries absorb that without losing a code
      dus_buf2 #(
        .W(dus_pkg::CODE_W)
      ) u_buf (
        .clk_i(SYS_CLK_I),
        .rst_i(SYS_RST_I),
        .in_data_i(load_word[g]),
        .in_valid_i(load[g]),
        .in_ready_o(buf_ready[g]),
        .out_data_o(DAC_CODE_O[g]),
        .out_valid_o(buf_valid[g]),
        .out_ready_i(DAC_READY_I[g])
      );

      // data bytes: stored on every write to their address with lane 0 on, never loaded here directly
      always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
          dac_low_byte[g] <= dus_pkg::BYTE_RST;
          dac_high_byte[g] <= dus_pkg::BYTE_RST;
        end else if (wr_fire && lane0) begin
          if (ch_hit(AVS_ADDRESS_I, g, dus_pkg::OFS_LOW)) begin
            dac_low_byte[g] <= AVS_WRITEDATA_I[7:0];
          end
          if (ch_hit(AVS_ADDRESS_I, g, dus_pkg::OFS_HIGH)) begin
            dac_high_byte[g] <= AVS_WRITEDATA_I[7:0];
          end
        end
      end

      // control register, unused bits six and five kept at zero
      always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
          dac_control_reg[g] <= dus_pkg::CTRL_RST;
        end else if (wr_fire && lane0 && ch_hit(AVS_ADDRESS_I, g, dus_pkg::OFS_CTRL)) begin
          dac_control_reg[g] <= AVS_WRITEDATA_I[7:0] & dus_pkg::CTRL_WMASK;
        end
      end

      // software-visible copy of the last code loaded into the buffer
      always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
          latch_code[g] <= dus_pkg::CODE_RST;
        end else if (load[g]) begin
          latch_code[g] <= load_word[g];
        end
      end

      // output drive only while enabled and biased; the converter is dead without bias
      always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
          DAC_OE_O[g] <= 1'b0;
        end else begin
          DAC_OE_O[g] <= dac_control_reg[g][dus_pkg::CTRL_EN_BIT] &&
                         reference_bias_on;
        end
      end
    end
  endgenerate

  assign DAC_VALID_O = buf_valid;

  // shared bias enable, off after reset
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      reference_bias_on <= dus_pkg::BIAS_RST;
    end else if (wr_fire && lane0 && AVS_ADDRESS_I == dus_pkg::OFS_BIAS) begin
      reference_bias_on <= AVS_WRITEDATA_I[0];
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    for (int c = 0; c < 2; c++) begin
      if (ch_hit(AVS_ADDRESS_I, c, dus_pkg::OFS_LOW)) begin
        next_rdata = {24'h00_0000, dac_low_byte[c]};
      end
      if (ch_hit(AVS_ADDRESS_I, c, dus_pkg::OFS_HIGH)) begin
        next_rdata = {24'h00_0000, dac_high_byte[c]};
      end
      if (ch_hit(AVS_ADDRESS_I, c, dus_pkg::OFS_CTRL)) begin
        next_rdata = {24'h00_0000, dac_control_reg[c]};
      end
      if (ch_hit(AVS_ADDRESS_I, c, dus_pkg::OFS_LATCH)) begin
        next_rdata = {20'h0_0000, latch_code[c]};
      end
    end
    if (AVS_ADDRESS_I == dus_pkg::OFS_BIAS) begin
      next_rdata = {31'h0000_0000, reference_bias_on};
    end
    if (AVS_ADDRESS_I == dus_pkg::OFS_STATUS) begin
      next_rdata[dus_pkg::STAT_PEND_LO +: 2] = pend;
      next_rdata[dus_pkg::STAT_FULL_LO +: 2] = ~buf_ready;
    end
  end

  // two-phase handshake: waitrequest drops for exactly the accepting cycle
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      bus_state <= dus_pkg::BUS_IDLE;
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= 32'h0000_0000;
    end else begin
      unique case (bus_state)
        dus_pkg::BUS_IDLE: begin
          if ((AVS_READ_I || AVS_WRITE_I) && !stall) begin
            bus_state <= dus_pkg::BUS_ACK;
            AVS_WAITREQUEST_O <= 1'b0;
            AVS_READDATA_O <= AVS_READ_I ? next_rdata : 32'h0000_0000;
          end
        end
        dus_pkg::BUS_ACK: begin
          bus_state <= dus_pkg::BUS_IDLE;
          AVS_WAITREQUEST_O <= 1'b1;
        end
      endcase
    end
  end
endmodule // dus_top
`default_nettype wire

// ===== dus_top_monitor.sv
// port-level checker of the converter update scheduler
`default_nettype none
module dus_top_monitor (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic TMR2_OVF_I,
  input wire logic TMR3_OVF_I,
  input wire logic TMR4_OVF_I,
  input wire logic [1:0][11:0] DAC_CODE_O,
  input wire logic [1:0] DAC_VALID_O,
  input wire logic [1:0] DAC_READY_I,
  input wire logic [1:0] DAC_OE_O
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] md0;
  logic [1:0] md1;
  logic wr;
  logic sel;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // a write acts only at its acknowledge edge with lane 0 on
  assign wr = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
  assign sel = (md0 == 2'h1) ? TMR3_OVF_I : (md0 == 2'h2) ? TMR4_OVF_I : (md0 == 2'h3) && TMR2_OVF_I;
  // shadow of both mode fields, so the checker knows which trigger counts
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      md0 <= 2'h0;
      md1 <= 2'h0;
    end else if (wr && AVS_ADDRESS_I == 8'h08) begin
      md0 <= AVS_WRITEDATA_I[4:3];
    end else if (wr && AVS_ADDRESS_I == 8'h18) begin
      md1 <= AVS_WRITEDATA_I[4:3];
    end
  end
  a_wait_single: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("wait low twice");
  a_head_hold: assert property (DAC_VALID_O[0] && !DAC_READY_I[0]
    |=> DAC_VALID_O[0] && $stable(DAC_CODE_O[0])) else $error("head lost");
  a_demand_load:
    assert property (wr && AVS_ADDRESS_I == 8'h04 && md0 == 2'h0 |=> DAC_VALID_O[0])
    else $error("no load");
  a_demand_other:
    assert property (wr && AVS_ADDRESS_I == 8'h14 && md1 == 2'h0 |=> DAC_VALID_O[1])
    else $error("no load ch1");
  a_low_only:
    assert property (wr && AVS_ADDRESS_I == 8'h00 && md0 == 2'h0 && !DAC_VALID_O[0]
    |=> !DAC_VALID_O[0]) else $error("low loaded");
  a_timer_load:
    assert property (sel && !DAC_VALID_O[0] |-> ##2 DAC_VALID_O[0]) else $error("no timer load");
  a_timer_quiet:
    assert property (md0 != 2'h0 && !$past(sel) && !DAC_VALID_O[0] && !$past(DAC_VALID_O[0])
    |=> !DAC_VALID_O[0]) else $error("early load");
  a_enable_off:
    assert property (wr && AVS_ADDRESS_I == 8'h18 && !AVS_WRITEDATA_I[7] |=> ##1 !DAC_OE_O[1])
    else $error("drive on");
  a_bias_off:
    assert property (wr && AVS_ADDRESS_I == 8'h20 && !AVS_WRITEDATA_I[0] |=> ##1 DAC_OE_O == 2'h0)
    else $error("drive on");
  c_timer: cover property (sel && !DAC_VALID_O[0]);
  c_stall: cover property ((AVS_WRITE_I && AVS_WAITREQUEST_O) [*4]);
  c_held: cover property (DAC_VALID_O[0] && !DAC_READY_I[0]);
endmodule // dus_top_monitor
bind dus_top dus_top_monitor i_dus_top_monitor (.SYS_CLK_I, .SYS_RST_I, .AVS_ADDRESS_I,
  .AVS_WRITE_I, .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I, .AVS_WAITREQUEST_O, .TMR2_OVF_I,
  .TMR3_OVF_I, .TMR4_OVF_I, .DAC_CODE_O, .DAC_VALID_O, .DAC_READY_I, .DAC_OE_O);
`default_nettype wire

// ===== dus_trig.sv
// per-channel timer overflow selection and pending load flag
`default_nettype none
module dus_trig (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] mode_i,
  input wire logic tmr2_ovf_i,
  input wire logic tmr3_ovf_i,
  input wire logic tmr4_ovf_i,
  input wire logic load_done_i,
  output logic pend_o
);
  logic hit;

  // only the selected timer counts, on-demand mode ignores all timers
  always_comb begin
    hit = 1'b0;
    unique case (dus_pkg::dus_mode_e'(mode_i))
      dus_pkg::MD_DEMAND: hit = 1'b0;
      dus_pkg::MD_TMR3: hit = tmr3_ovf_i;
      dus_pkg::MD_TMR4: hit = tmr4_ovf_i;
      dus_pkg::MD_TMR2: hit = tmr2_ovf_i;
    endcase
  end

  // a new overflow beats the clearing load so no event is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_o <= 1'b0;
    end else begin
      pend_o <= hit | (pend_o & ~load_done_i);
    end
  end
endmodule // dus_trig
`default_nettype wire

// ===== test_dus_top.sv
// self-checking bench of the converter update scheduler
`default_nettype none
module test_dus_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h1;
  logic [2:0] tmr = 3'h0;
  logic slow = 1'b0;
  logic [31:0] rdata;
  logic waitreq;
  logic [1:0][11:0] code;
  logic [1:0] valid;
  logic [1:0] ready;
  logic [1:0] oe;
  logic [11:0] dq[2][$];
  logic [31:0] rq[$];
  logic [7:0] h;
  logic [7:0] l;
  int fails = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  dus_top i_dus_top (.SYS_CLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(waitreq), .TMR2_OVF_I(tmr[0]), .TMR3_OVF_I(tmr[1]), .TMR4_OVF_I(tmr[2]),
    .DAC_CODE_O(code), .DAC_VALID_O(valid), .DAC_READY_I(ready), .DAC_OE_O(oe));
  for (genvar c = 0; c < 2; c++) begin : g_sink
    dus_sink i_dus_sink (.clk_i(clk), .rst_i(rst), .slow_i(slow), .ready_o(ready[c]));
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [11:0] fmt(input logic [7:0] hb, input logic [7:0] lb,
                                      input logic [2:0] df);
    return 12'({hb, lb} >> (df[2] ? 3'h4 : df));
  endfunction
  // one bus access held until waitrequest is seen low; reads note their data
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w) rq.push_back(d);
    @(posedge clk);
    addr <= a;
    wdata <= w ? d : 32'h0;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (waitreq !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // low byte first, then high byte, noting the code the latch must get
  task automatic put(input int c, input logic [7:0] hb, input logic [7:0] lb,
                     input logic [2:0] df);
    acc(1'b1, 8'(c * 16), {24'h0, lb});
    dq[c].push_back(fmt(hb, lb, df));
    acc(1'b1, 8'(c * 16 + 4), {24'h0, hb});
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge clk);
    tmr <= m;
    @(posedge clk);
    tmr <= 3'h0;
    repeat (4) @(posedge clk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // results are matched oldest first against what the drivers noted
  always @(posedge clk) begin
    if (rd && waitreq === 1'b0) chk("readback", rdata, rq.pop_front());
    for (int c = 0; c < 2; c++) begin
      if (valid[c] === 1'b1 && ready[c] === 1'b1) begin
        if (dq[c].size() == 0) chk("extra load", 32'h1, 32'h0);
        else chk("code", 32'(code[c]), 32'(dq[c].pop_front()));
      end
    end
  end
  // a hang ends the run long after the few hundred cycles it needs
  initial begin
    #200us;
    fails++;
    stop_test();
  end
  initial begin
    logic [11:0] last;
    void'($urandom(20));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    acc(1'b1, 8'h20, 32'h1);
    // every format on both channels, with both end codes
    for (int i = 0; i < 5; i++) begin
      for (int c = 0; c < 2; c++) begin
        acc(1'b1, 8'(c * 16 + 8), {24'h0, 8'h80 | 8'(i)});
        h = (i == 0) ? 8'h00 : (i == 4) ? 8'hff : 8'($urandom);
        l = (i == 0) ? 8'h00 : (i == 4) ? 8'hff : 8'($urandom);
        put(c, h, l, 3'(i));
      end
    end
    // low byte alone and a high write without lane 0 load no code
    acc(1'b1, 8'h00, 32'h5a);
    be <= 4'he;
    acc(1'b1, 8'h04, 32'h12);
    be <= 4'h1;
    acc(1'b0, 8'h0c, 32'hfff);
    last = fmt(8'h3c, 8'h5a, 3'h4);
    dq[0].push_back(last);
    acc(1'b1, 8'h04, 32'h3c);
    // 8-bit use: low byte preset once to zero, then high writes only
    acc(1'b1, 8'h00, 32'h0);
    for (int k = 0; k < 2; k++) begin
      h = 8'($urandom);
      dq[0].push_back(fmt(h, 8'h00, 3'h4));
      acc(1'b1, 8'h04, {24'h0, h});
    end
    last = fmt(h, 8'h00, 3'h4);
    // timer modes: held until the selected overflow, one load per pulse
    for (int m = 1; m < 4; m++) begin
      acc(1'b1, 8'h08, {24'h0, 8'h80 | 8'(m << 3)});
      h = 8'($urandom);
      l = 8'($urandom);
      put(0, h, l, 3'h0);
      pulse(~3'(1 << (m % 3)));
      acc(1'b0, 8'h0c, {20'h0, last});
      pulse(3'(1 << (m % 3)));
      dq[0].push_back(fmt(h, l, 3'h0));
      pulse(3'(1 << (m % 3)));
      last = fmt(h, l, 3'h0);
      acc(1'b0, 8'h0c, {20'h0, last});
      put(1, l, h, 3'h4);
    end
    // slow receiver: buffer fills, high writes stall, nothing is lost
    acc(1'b1, 8'h08, 32'h80);
    slow <= 1'b1;
    for (int k = 0; k < 6; k++) put(0, 8'($urandom), 8'($urandom), 3'h0);
    slow <= 1'b0;
    repeat (8) @(posedge clk);
    acc(1'b0, 8'h24, 32'h0);
    chk("pending", 32'(dq[0].size() + dq[1].size()), 32'h0);
    // output drive follows the channel 1 enable bit and the shared bias
    chk("drive", 32'(oe), 32'h3);
    acc(1'b1, 8'h18, 32'h04);
    repeat (3) @(posedge clk);
    chk("drive", 32'(oe), 32'h1);
    acc(1'b1, 8'h20, 32'h0);
    repeat (3) @(posedge clk);
    chk("drive", 32'(oe), 32'h0);
    acc(1'b1, 8'h08, 32'hff);
    acc(1'b0, 8'h08, 32'h9f);
    acc(1'b0, 8'h30, 32'h0);
    repeat (4) @(posedge clk);
    stop_test();
  end
endmodule // test_dus_top
`default_nettype wire
